// ===== dv/ppc_pipe_model.sv
`timescale 1ns/10ps
`default_nettype none
module ppc_pipe_model
   import ppc_pkg::*;
(
   // clock and reset
   input  wire logic           clk_sys,
   input  wire logic           reset,
   // issue enable
   input  wire logic           en,
   // references toward the checker
   output var ppc_mem_req_type mem_req
);
   integer seed;
   integer i;
   initial begin
      seed    = 96595;
   end
   //===================================================================
   // reference stream
   // permission bits are forced set three times in four and random otherwise,
   // so passes and both kinds of fault interleave with idle cycles
   always @(posedge clk_sys) begin
      if (reset || !en) begin
         mem_req <= '0;
      end else begin
         mem_req.valid            <= ($random(seed) % 4) != 0;
         mem_req.addr             <= $random(seed);
         mem_req.write            <= $random(seed) % 2 != 0;
         mem_req.size             <= ppc_size_type'(2'($random(seed)));
         mem_req.current_level    <= 2'($random(seed));
         mem_req.align_check_flag <= ($random(seed) % 4) != 0;
         for (i = 0; i < PG_LEVELS; i++) begin
            mem_req.entry[i] <= $random(seed) |
               ((($random(seed) % 4) != 0) ? 32'h0000_0006 : 32'h0000_0000);
         end
      end
   end
endmodule
`default_nettype wire

// ===== dv/ppc_protect_check_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) check(nm, 32'(e), 32'(g))
module ppc_protect_check_tb_top
   import ppc_pkg::*;
;
   logic              clk_sys, reset, en, irq;
   ppc_mem_req_type   mem_req, req_q;
   ppc_mem_rsp_type   mem_rsp;
   ppc_sel_req_type   sel_req;
   ppc_sel_rsp_type   sel_rsp;
   logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic              s_axi_rready;
   logic [REG_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0]       s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]        s_axi_wstrb;
   logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
   logic [15:0]       d;
   integer n_fail, comparisons, seed, i, cfg, v, lvl, mis, pf, ua;
   integer cyc = 0;
   integer al_u, al_rw, ok, m_wp, m_am, m_ev, m_mask, m_info, m_addr;

   ppc_protect_check ppc_protect_check_inst (.clk_sys, .reset, .mem_req,
      .mem_rsp, .sel_req, .sel_rsp, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq);
   ppc_pipe_model ppc_pipe_model_inst (.clk_sys, .reset, .en, .mem_req);

   always #12.5 clk_sys = ~clk_sys;

   //===================================================================
   // reporting
   task automatic check(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic final_report();
      $display("mismatches %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // a hang counts as a mismatch and still ends in the report
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_fail++;
         final_report();
      end
   end

   //===================================================================
   // bus tasks, each starts on a fresh rising edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat);
      logic aw, w;
      aw = 0;
      w  = 0;
      @(posedge clk_sys);
      s_axi_awvalid <= 1;
      s_axi_awaddr  <= a;
      s_axi_wvalid  <= 1;
      s_axi_wdata   <= dat;
      s_axi_bready  <= 1;
      // no cycle count assumed: bvalid ends this wait, only the bench timeout ends a hang
      forever begin
         @(posedge clk_sys);
         if (s_axi_bvalid === 1'b1) break;
         if (!aw && s_axi_awready === 1'b1) begin
            aw = 1;
            s_axi_awvalid <= 0;
         end
         if (!w && s_axi_wready === 1'b1) begin
            w = 1;
            s_axi_wvalid <= 0;
         end
      end
      rsp = s_axi_bresp;
      s_axi_bready <= 0;
   endtask

   task automatic axi_rd(input logic [7:0] a);
      logic ar;
      ar = 0;
      @(posedge clk_sys);
      s_axi_arvalid <= 1;
      s_axi_araddr  <= a;
      s_axi_rready  <= 1;
      forever begin
         @(posedge clk_sys);
         if (s_axi_rvalid === 1'b1) break;
         if (!ar && s_axi_arready === 1'b1) begin
            ar = 1;
            s_axi_arvalid <= 0;
         end
      end
      rd  = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 0;
   endtask

   task automatic sel_op(input ppc_sel_op_type op, input logic [15:0] dst,
                         input logic [15:0] src, input logic [1:0] cl,
                         input logic [1:0] dl);
      @(posedge clk_sys);
      sel_req <= '{1'b1, op, dst, src, cl, dl};
      @(posedge clk_sys);
      sel_req.valid <= 0;
      @(negedge clk_sys);
      `CHK("sel_done", 1, sel_rsp.done);
   endtask

   //===================================================================
   // reference model, one answer per reference one cycle later
   always @(posedge clk_sys) req_q <= mem_req;
   always @(negedge clk_sys) begin
      if (!reset) begin
         v   = req_q.valid;
         lvl = req_q.current_level;
         case (req_q.size)
            SZ_BYTE: ua = 0;
            SZ_HALF: ua = req_q.addr[0];
            SZ_WORD: ua = |req_q.addr[1:0];
            default: ua = |req_q.addr[2:0];
         endcase
         al_u  = req_q.entry[0][2] & req_q.entry[1][2];
         al_rw = req_q.entry[0][1] & req_q.entry[1][1];
         mis = v && lvl == 3 && m_am && req_q.align_check_flag && ua;
         pf  = v && !mis && ((lvl == 3 && !al_u) ||
               (req_q.write && !al_rw && (lvl == 3 || m_wp)));
         `CHK("mem_start", v && !mis && !pf, mem_rsp.mem_start);
         `CHK("misalign", mis, mem_rsp.misalign_fault);
         `CHK("page_fault", pf, mem_rsp.page_fault);
         if (v) begin
            `CHK("rsp_addr", req_q.addr, mem_rsp.addr);
            `CHK("rsp_write", req_q.write, mem_rsp.write);
            `CHK("rsp_user", lvl == 3, mem_rsp.user);
         end
         if (mis || pf) begin
            m_ev   = m_ev | (mis ? 1 : 2);
            m_info = mis + 2 * req_q.write + 4 * (lvl == 3);
            m_addr = req_q.addr;
         end
      end
   end

   //===================================================================
   // main sequence
   initial begin
      {clk_sys, en, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, sel_req} = '0;
      s_axi_wstrb = 4'hf;
      reset = 1;
      {n_fail, comparisons, m_wp, m_am, m_ev, m_info, m_addr} = '0;
      seed = 96595;
      repeat (16) @(posedge clk_sys);
      reset <= 0;
      axi_rd(OFS_CTRL);
      `CHK("ctrl_reset", 0, rd);
      for (i = 0; i < 16; i++) begin
         d = {14'($random(seed)), i[3:2]};
         sel_op(SEL_ADJUST, d, {14'($random(seed)), i[1:0]}, 0, 0);
         `CHK("adj_sel", (i[3:2] < i[1:0]) ? {d[15:2], i[1:0]} : d,
              sel_rsp.result_sel);
         `CHK("adj_flag", i[3:2] < i[1:0], sel_rsp.adjusted);
         `CHK("adj_ok", 1, sel_rsp.access_ok);
      end
      for (i = 0; i < 64; i++) begin
         ok = i[5:4] <= i[1:0] && i[3:2] <= i[1:0];
         sel_op(SEL_DATA, {14'($random(seed)), i[3:2]}, 0, i[5:4], i[1:0]);
         `CHK("data_ok", ok, sel_rsp.access_ok);
         if (!ok) m_ev = m_ev | 4;
      end
      // every write-protect and align-mask setting
      for (cfg = 0; cfg < 4; cfg++) begin
         m_wp   = cfg % 2;
         m_am   = cfg / 2;
         m_mask = (cfg == 0) ? 0 : 7;
         axi_wr(OFS_CTRL, cfg);
         `CHK("ctrl_wr", RESP_OKAY, rsp);
         axi_wr(OFS_IRQ_MASK, m_mask);
         axi_rd(OFS_CTRL);
         `CHK("ctrl_rd", cfg, rd);
         `CHK("irq_lvl", (m_ev & m_mask) != 0, irq);
         axi_rd(OFS_IRQ_STAT);
         `CHK("stat", m_ev, rd);
         m_ev = 0;
         repeat (3) @(posedge clk_sys);
         `CHK("irq_clr", 0, irq);
         en <= 1;
         repeat (300) @(posedge clk_sys);
         en <= 0;
         repeat (4) @(posedge clk_sys);
         `CHK("irq_ev", (m_ev & m_mask) != 0, irq);
         axi_rd(OFS_FLT_INFO);
         `CHK("info", m_info, rd);
         axi_rd(OFS_FLT_ADDR);
         `CHK("faddr", m_addr, rd);
      end
      axi_wr(8'h20, 32'h0000_0001);
      `CHK("unmap_wr", RESP_SLVERR, rsp);
      axi_rd(8'h20);
      `CHK("unmap_rresp", RESP_SLVERR, rsp);
      `CHK("unmap_rd", 0, rd);
      axi_wr(OFS_IRQ_STAT, 32'hffff_ffff);
      `CHK("ro_wr", RESP_OKAY, rsp);
      // a write without lane 0 must leave control untouched
      s_axi_wstrb <= 4'he;
      axi_wr(OFS_CTRL, 32'h0000_0000);
      `CHK("nolane_wr", RESP_OKAY, rsp);
      axi_rd(OFS_CTRL);
      `CHK("ctrl_kept", 3, rd);
      final_report();
   end
endmodule
`default_nettype wire

// ===== shared/ppc_pkg.sv
//======================================================================
// Notes on behaviour
// - adjust op raises destination requestor level to the source's if lower.
// - data access allowed only if current and requestor level <= descriptor.
// - alignment check only at level 3 with mask and flag both set.
// - when alignment check is on, unaligned reference faults, not performed.
// - levels 0, 1 and 2 never raise a misalignment fault.
// - page checks finish before the memory cycle is started.
// - domain or page-type failure suppresses the cycle and signals page fault.
// - checks run alongside translation, adding no cycle to a reference.
// - write-allow is entry bit 1, user/supervisor is entry bit 2.
// - permission bits of every paging level are evaluated.
// - user/supervisor 0 means supervisor-only, 1 means user page.
// - levels 0 to 2 are supervisor mode, level 3 is user mode.
// - supervisor reaches all pages, user only user pages, else fault.
// - write-allow 0 means read-only, 1 means read/write.
// - write-protect clear: supervisor may write any page.
// - write-protect set: read-only pages unwritable at every level.
// - user writes need user and read/write; user reads need user only.
package ppc_pkg;

   //===================================================================
   // widths and field positions
   localparam int PG_LEVELS     = 2;
   localparam int REG_AW        = 8;
   localparam int PTE_RW_BIT    = 1;
   localparam int PTE_US_BIT    = 2;
   localparam int CTRL_WP_BIT   = 0;
   localparam int CTRL_AM_BIT   = 1;
   localparam int EV_MISALIGN   = 0;
   localparam int EV_PAGE       = 1;
   localparam int EV_SEG_DENY   = 2;
   localparam int EV_W          = 3;

   //===================================================================
   // privilege levels
   localparam logic [1:0] LVL_USER = 2'h3;

   //===================================================================
   // register map, byte addresses
   localparam logic [REG_AW-1:0] OFS_CTRL      = 8'h00;
   localparam logic [REG_AW-1:0] OFS_IRQ_STAT  = 8'h04;
   localparam logic [REG_AW-1:0] OFS_IRQ_MASK  = 8'h08;
   localparam logic [REG_AW-1:0] OFS_FLT_INFO  = 8'h0C;
   localparam logic [REG_AW-1:0] OFS_FLT_ADDR  = 8'h10;

   //===================================================================
   // reset values and bus answers
   localparam logic [1:0]      RST_CTRL   = 2'h0;
   localparam logic [EV_W-1:0] RST_EV     = 3'h0;
   localparam logic [31:0]     RST_WORD   = 32'h0000_0000;
   localparam logic [1:0]      RESP_OKAY  = 2'h0;
   localparam logic [1:0]      RESP_SLVERR = 2'h2;

   //===================================================================
   // types
   typedef enum logic {
      SEL_ADJUST = 1'b0,
      SEL_DATA   = 1'b1
   } ppc_sel_op_type;

   typedef enum logic [1:0] {
      SZ_BYTE  = 2'b00,
      SZ_HALF  = 2'b01,
      SZ_WORD  = 2'b10,
      SZ_DWORD = 2'b11
   } ppc_size_type;

   typedef struct packed {
      logic                        valid;
      logic [31:0]                 addr;
      logic                        write;
      ppc_size_type                size;
      logic [1:0]                  current_level;
      logic                        align_check_flag;
      logic [PG_LEVELS-1:0][31:0]  entry;
   } ppc_mem_req_type;

   typedef struct packed {
      logic        mem_start;
      logic [31:0] addr;
      logic        write;
      logic        misalign_fault;
      logic        page_fault;
      logic        user;
   } ppc_mem_rsp_type;

   typedef struct packed {
      logic           valid;
      ppc_sel_op_type op;
      logic [15:0]    dst_sel;
      logic [15:0]    src_sel;
      logic [1:0]     current_level;
      logic [1:0]     descriptor_level;
   } ppc_sel_req_type;

   typedef struct packed {
      logic        done;
      logic [15:0] result_sel;
      logic        adjusted;
      logic        access_ok;
   } ppc_sel_rsp_type;

endpackage

// ===== verilog/ppc_page_perm.sv
`timescale 1ns/10ps
`default_nettype none
module ppc_page_perm
   import ppc_pkg::*;
(
   // walk entries of one translation
   input  wire logic [PG_LEVELS-1:0][31:0] entry,
   // access attributes
   input  wire logic                       write,
   input  wire logic                       user,
   input  wire logic                       wp,
   // verdict
   output logic                            all_user,
   output logic                            all_rw,
   output logic                            fault
);

   logic [PG_LEVELS-1:0] us_bits;
   logic [PG_LEVELS-1:0] rw_bits;

   //===================================================================
   // permission bits of every level
   genvar gi;
   generate
      for (gi = 0; gi < PG_LEVELS; gi++) begin : g_lvl
         assign us_bits[gi] = entry[gi][PTE_US_BIT];
         assign rw_bits[gi] = entry[gi][PTE_RW_BIT];
      end
   endgenerate

   // most restrictive level wins: any supervisor or read-only level
   assign all_user = &us_bits;
   assign all_rw   = &rw_bits;

   wire dom_fail  = user & ~all_user;
   wire type_fail = write & ~all_rw & (user | wp);
   assign fault   = dom_fail | type_fail;

endmodule
`default_nettype wire

// ===== verilog/ppc_protect_check.sv
`timescale 1ns/10ps
`default_nettype none
module ppc_protect_check
   import ppc_pkg::*;
(
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset,
   // memory reference, with translation result
   input  wire ppc_mem_req_type   mem_req,
   output ppc_mem_rsp_type        mem_rsp,
   // selector operations
   input  wire ppc_sel_req_type   sel_req,
   output ppc_sel_rsp_type        sel_rsp,
   // axi4-lite write address
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [REG_AW-1:0] s_axi_awaddr,
   // axi4-lite write data
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   // axi4-lite write response
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic [1:0]             s_axi_bresp,
   // axi4-lite read address
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [REG_AW-1:0] s_axi_araddr,
   // axi4-lite read data
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   // interrupt
   output logic                   irq
);

   //===================================================================
   // state
   ppc_mem_rsp_type       mem_rsp_ff;
   ppc_sel_rsp_type       sel_rsp_ff;
   logic [1:0]            ctrl_ff;
   logic [EV_W-1:0]       stat_ff;
   logic [EV_W-1:0]       mask_ff;
   logic [31:0]           flt_addr_ff;
   logic [2:0]            flt_info_ff;
   logic                  awready_ff;
   logic                  wready_ff;
   logic                  bvalid_ff;
   logic [1:0]            bresp_ff;
   logic                  arready_ff;
   logic                  rvalid_ff;
   logic [31:0]           rdata_ff;
   logic [1:0]            rresp_ff;
   logic [REG_AW-1:0]     awaddr_ff;
   logic [31:0]           wdata_ff;
   logic                  wstrb0_ff;
   logic                  irq_ff;

   //===================================================================
   // alignment check
   wire is_user  = (mem_req.current_level == LVL_USER);
   wire align_en = is_user & ctrl_ff[CTRL_AM_BIT]
                   & mem_req.align_check_flag;
   logic [2:0] low_mask;
   assign low_mask = (mem_req.size == SZ_BYTE) ? 3'h0 :
                     (mem_req.size == SZ_HALF) ? 3'h1 :
                     (mem_req.size == SZ_WORD) ? 3'h3 : 3'h7;
   wire unaligned = |(mem_req.addr[2:0] & low_mask);
   wire misalign  = mem_req.valid & align_en & unaligned;

   //===================================================================
   // page permission, in the same cycle as the translation result
   wire pg_fault_raw;
   ppc_page_perm u_perm (
      .entry    (mem_req.entry),
      .write    (mem_req.write),
      .user     (is_user),
      .wp       (ctrl_ff[CTRL_WP_BIT]),
      .all_user (),
      .all_rw   (),
      .fault    (pg_fault_raw)
   );
   // misalignment wins: a reference that never starts cannot page fault
   wire pg_fault  = mem_req.valid & ~misalign & pg_fault_raw;
   wire may_start = mem_req.valid & ~misalign & ~pg_fault_raw;

   //===================================================================
   // selector operations
   wire [1:0] dst_lvl   = sel_req.dst_sel[1:0];
   wire [1:0] src_lvl   = sel_req.src_sel[1:0];
   wire       raise     = (dst_lvl < src_lvl);
   wire [15:0] adj_sel  = raise ? {sel_req.dst_sel[15:2], src_lvl}
                                : sel_req.dst_sel;
   wire       data_ok   = (sel_req.current_level <= sel_req.descriptor_level)
                        & (dst_lvl <= sel_req.descriptor_level);
   wire       is_adjust = (sel_req.op == SEL_ADJUST);
   wire       seg_deny  = sel_req.valid & ~is_adjust & ~data_ok;

   //===================================================================
   // register bus decode
   wire aw_hs = s_axi_awvalid & awready_ff;
   wire w_hs  = s_axi_wvalid & wready_ff;
   wire ar_hs = s_axi_arvalid & arready_ff;
   wire aw_have = aw_hs | ~awready_ff;
   wire w_have  = w_hs | ~wready_ff;
   wire wr_go   = aw_have & w_have & ~bvalid_ff;
   wire [REG_AW-1:0] wr_addr = aw_hs ? s_axi_awaddr : awaddr_ff;
   wire [31:0]       wr_data = w_hs ? s_axi_wdata : wdata_ff;
   wire              wr_lane = w_hs ? s_axi_wstrb[0] : wstrb0_ff;
   wire wr_ctrl  = wr_go & wr_lane & (wr_addr == OFS_CTRL);
   wire wr_mask  = wr_go & wr_lane & (wr_addr == OFS_IRQ_MASK);
   wire wr_hit   = (wr_addr == OFS_CTRL) | (wr_addr == OFS_IRQ_MASK)
                 | (wr_addr == OFS_IRQ_STAT) | (wr_addr == OFS_FLT_INFO)
                 | (wr_addr == OFS_FLT_ADDR);
   wire rd_stat  = ar_hs & (s_axi_araddr == OFS_IRQ_STAT);
   wire rd_hit   = (s_axi_araddr == OFS_CTRL)
                 | (s_axi_araddr == OFS_IRQ_STAT)
                 | (s_axi_araddr == OFS_IRQ_MASK)
                 | (s_axi_araddr == OFS_FLT_INFO)
                 | (s_axi_araddr == OFS_FLT_ADDR);
   logic [31:0] rd_word;
   assign rd_word =
      (s_axi_araddr == OFS_CTRL)     ? {30'h0000_0000, ctrl_ff} :
      (s_axi_araddr == OFS_IRQ_STAT) ? {29'h0000_0000, stat_ff} :
      (s_axi_araddr == OFS_IRQ_MASK) ? {29'h0000_0000, mask_ff} :
      (s_axi_araddr == OFS_FLT_INFO) ? {29'h0000_0000, flt_info_ff} :
      (s_axi_araddr == OFS_FLT_ADDR) ? flt_addr_ff : RST_WORD;

   //===================================================================
   // interrupt status: an event in the clearing read's cycle survives
   wire [EV_W-1:0] events = {seg_deny, pg_fault, misalign};
   wire [EV_W-1:0] nxt_stat = (rd_stat ? RST_EV : stat_ff) | events;
   wire            any_flt  = misalign | pg_fault;

   //===================================================================
   // check results, one register stage that the translation has anyway
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mem_rsp_ff <= '0;
         sel_rsp_ff <= '0;
      end else begin
         mem_rsp_ff.mem_start      <= may_start;
         mem_rsp_ff.addr           <= mem_req.addr;
         mem_rsp_ff.write          <= mem_req.write;
         mem_rsp_ff.misalign_fault <= misalign;
         mem_rsp_ff.page_fault     <= pg_fault;
         mem_rsp_ff.user           <= is_user;
         sel_rsp_ff.done           <= sel_req.valid;
         sel_rsp_ff.result_sel     <= is_adjust ? adj_sel
                                                : sel_req.dst_sel;
         sel_rsp_ff.adjusted       <= is_adjust & raise;
         sel_rsp_ff.access_ok      <= is_adjust | data_ok;
      end
   end

   //===================================================================
   // software registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ctrl_ff     <= RST_CTRL;
         mask_ff     <= RST_EV;
         stat_ff     <= RST_EV;
         flt_addr_ff <= RST_WORD;
         flt_info_ff <= 3'h0;
         irq_ff      <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= wr_data[1:0];
         end
         if (wr_mask) begin
            mask_ff <= wr_data[EV_W-1:0];
         end
         stat_ff <= nxt_stat;
         if (any_flt) begin
            flt_addr_ff <= mem_req.addr;
            flt_info_ff <= {is_user, mem_req.write, misalign};
         end
         irq_ff <= |(stat_ff & mask_ff);
      end
   end

   //===================================================================
   // axi4-lite write channels, taken in either order
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
         awaddr_ff  <= '0;
         wdata_ff   <= RST_WORD;
         wstrb0_ff  <= 1'b0;
      end else begin
         if (aw_hs) begin
            awaddr_ff  <= s_axi_awaddr;
            awready_ff <= 1'b0;
         end
         if (w_hs) begin
            wdata_ff  <= s_axi_wdata;
            wstrb0_ff <= s_axi_wstrb[0];
            wready_ff <= 1'b0;
         end
         if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_ff & s_axi_bready) begin
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
         end
      end
   end

   //===================================================================
   // axi4-lite read channels
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= RST_WORD;
         rresp_ff   <= RESP_OKAY;
      end else if (ar_hs) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rdata_ff   <= rd_word;
         rresp_ff   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_ff & s_axi_rready) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
      end
   end

   assign mem_rsp       = mem_rsp_ff;
   assign sel_rsp       = sel_rsp_ff;
   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;
   assign irq           = irq_ff;

   //===================================================================
   // assertions
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   wire req_user_wr = mem_req.valid & is_user & mem_req.write;
   wire req_sup_wr  = mem_req.valid & ~is_user & mem_req.write;
   wire entries_rw  = mem_req.entry[0][PTE_RW_BIT]
                    & mem_req.entry[1][PTE_RW_BIT];
   wire entries_us  = mem_req.entry[0][PTE_US_BIT]
                    & mem_req.entry[1][PTE_US_BIT];

   sequence s_adjust_req;
      sel_req.valid && sel_req.op == SEL_ADJUST;
   endsequence
   sequence s_unaligned_user;
      mem_req.valid && is_user && unaligned
      && ctrl_ff[CTRL_AM_BIT] && mem_req.align_check_flag;
   endsequence

   a_adjust_raise: assert property (s_adjust_req |=>
      sel_rsp.result_sel[1:0] == (($past(dst_lvl) < $past(src_lvl))
                                  ? $past(src_lvl) : $past(dst_lvl)))
      else $error("adjusted level wrong");
   a_data_priv: assert property (sel_req.valid && sel_req.op == SEL_DATA
      |=> sel_rsp.access_ok == ($past(sel_req.current_level)
          <= $past(sel_req.descriptor_level) && $past(dst_lvl)
          <= $past(sel_req.descriptor_level)))
      else $error("data segment verdict wrong");
   a_align_fault: assert property (s_unaligned_user |=>
      mem_rsp.misalign_fault && !mem_rsp.mem_start && !mem_rsp.page_fault)
      else $error("unaligned user reference not faulted");
   a_align_gate: assert property (mem_rsp.misalign_fault |->
      $past(ctrl_ff[CTRL_AM_BIT]) && $past(mem_req.align_check_flag))
      else $error("misalign fault without enables");
   a_no_sup_align: assert property (mem_req.valid && !is_user
      |=> !mem_rsp.misalign_fault)
      else $error("misalign fault at supervisor level");
   a_fault_blocks: assert property ((mem_rsp.page_fault
      || mem_rsp.misalign_fault) |-> !mem_rsp.mem_start)
      else $error("memory cycle started on fault");
   a_no_latency: assert property (mem_req.valid |=> (mem_rsp.mem_start
      ^ (mem_rsp.page_fault | mem_rsp.misalign_fault)))
      else $error("reference not answered next cycle");
   a_user_domain: assert property (mem_req.valid && is_user && !entries_us
      && !misalign |=> mem_rsp.page_fault)
      else $error("user reached supervisor page");
   a_user_write: assert property (req_user_wr && entries_us && !misalign
      |=> mem_rsp.page_fault == !$past(entries_rw))
      else $error("user write verdict wrong");
   a_sup_write: assert property (req_sup_wr |=>
      mem_rsp.page_fault == ($past(ctrl_ff[CTRL_WP_BIT])
                             && !$past(entries_rw)))
      else $error("supervisor write verdict wrong");
   a_irq_level: assert property (mem_req.valid && misalign
      && mask_ff[EV_MISALIGN] && !wr_mask |=> ##1 irq)
      else $error("interrupt not raised");

endmodule
`default_nettype wire
